/* ext_bus_if.sv */
// external memory bus interface: register slave plus bus cycle sequencer
// assumes synchronous pin inputs and an Avalon-MM master with waitrequest
`timescale 1ns/100ps
`default_nettype none
module ext_bus_if (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  processorModeSelect,
    input  wire logic                  busWidthSelect,
    input  wire logic                  holdRequestN,
    input  wire logic                  waitRequestN,
    input  wire logic [15:0]           extDataIn,
    output ext_bus_pkg::ext_pins_s     extPins
);
    import ext_bus_pkg::*;

    core_s       s_r;
    core_s       s_nxt;
    logic [31:0] regView;
    logic [31:0] beMask;
    logic [31:0] merged;
    logic        busy;
    logic        wrTake;
    logic        word16;
    logic        laneLo;
    logic        laneHi;

    // outputs straight from the state register
    assign avs_readdata    = s_r.avsRdata;
    assign avs_waitrequest = s_r.waitReq;
    assign extPins         = s_r.pins;

    // register read view and byte-enable merge
    always_comb begin
        regView = '0;
        busy = s_r.pend || (s_r.fsm != ST_IDLE && s_r.fsm != ST_HOLD);
        unique case (avs_address)
            OFS_CTRL: begin
                regView[CTRL_SINGLE] = s_r.singleStrobe;
                regView[CTRL_MUX]    = s_r.muxBus;
            end
            OFS_ADDR:  regView[ADDR_W-1:0] = s_r.addr;
            OFS_WDATA: regView[DATA_W-1:0] = s_r.wdata;
            OFS_CMD: begin
                regView[CMD_GO]         = s_r.pend;
                regView[CMD_WRITE]      = s_r.isWrite;
                regView[CMD_WORD]       = s_r.wordAcc;
                regView[CMD_CS_LO +: 2] = s_r.csSel;
            end
            OFS_STATUS: begin
                regView[STS_BUSY]  = busy;
                regView[STS_HOLD]  = (s_r.fsm == ST_HOLD);
                regView[STS_MICRO] = s_r.microMode;
                regView[STS_BYTE]  = busWidthSelect;
                regView[STS_DONE]  = s_r.done;
                regView[STS_WAIT]  = (s_r.fsm == ST_STRB) && !waitRequestN;
            end
            OFS_RDATA: regView[DATA_W-1:0] = s_r.rdata;
            default:   regView = '0;
        endcase
        beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        merged = (regView & ~beMask) | (avs_writedata & beMask);
        wrTake = avs_write && !s_r.waitReq;
    end

    // next state: bus slave, mode capture, sequencer, pins
    always_comb begin
        s_nxt = s_r;
        // one wait cycle, then a single ready cycle per request
        s_nxt.waitReq = 1'b1;
        if ((avs_read || avs_write) && s_r.waitReq) begin
            s_nxt.waitReq  = 1'b0;
            s_nxt.avsRdata = regView;
        end
        if (wrTake) begin
            unique case (avs_address)
                OFS_CTRL: begin
                    if (!busy) begin
                        s_nxt.singleStrobe = merged[CTRL_SINGLE];
                        s_nxt.muxBus       = merged[CTRL_MUX];
                    end
                end
                OFS_ADDR:  s_nxt.addr  = merged[ADDR_W-1:0];
                OFS_WDATA: s_nxt.wdata = merged[DATA_W-1:0];
                OFS_CMD: begin
                    // no external cycles in single-chip mode
                    if (!busy && s_r.microMode && merged[CMD_GO]) begin
                        s_nxt.pend    = 1'b1;
                        s_nxt.isWrite = merged[CMD_WRITE];
                        s_nxt.wordAcc = merged[CMD_WORD];
                        s_nxt.csSel   = merged[CMD_CS_LO +: 2];
                    end
                end
                OFS_STATUS: begin
                    if (avs_writedata[STS_DONE] && avs_byteenable[0]) begin
                        s_nxt.done = 1'b0; // write one to clear
                    end
                end
                default: ;
            endcase
        end
        // mode pin caught once after reset
        if (!s_r.modeTaken) begin
            s_nxt.modeTaken = 1'b1;
            s_nxt.microMode = processorModeSelect;
        end
        // 8-bit bus never makes a word access
        word16 = s_r.wordAcc && !busWidthSelect && !s_r.addr[0];
        unique case (s_r.fsm)
            ST_IDLE: begin
                if (s_r.microMode && !holdRequestN) begin
                    s_nxt.fsm = ST_HOLD;
                end else if (s_r.pend) begin
                    s_nxt.fsm  = ST_ADDR;
                    s_nxt.pend = 1'b0;
                end
            end
            ST_ADDR: s_nxt.fsm = ST_STRB;
            ST_STRB: begin
                if (waitRequestN) begin
                    s_nxt.fsm  = ST_IDLE;
                    s_nxt.done = 1'b1; // set beats a clear
                    if (!s_r.isWrite) begin
                        if (word16) begin
                            s_nxt.rdata = extDataIn;
                        end else if (!busWidthSelect && s_r.addr[0]) begin
                            s_nxt.rdata = {8'h00, extDataIn[15:8]};
                        end else begin
                            s_nxt.rdata = {8'h00, extDataIn[7:0]};
                        end
                    end
                end
            end
            ST_HOLD: begin
                if (holdRequestN) begin
                    s_nxt.fsm = ST_IDLE;
                end
            end
        endcase
        // pins follow the next state so they line up with s_r.fsm
        s_nxt.pins = PINS_IDLE;
        word16 = s_nxt.wordAcc && !busWidthSelect && !s_nxt.addr[0];
        laneHi = word16 || (!busWidthSelect && s_nxt.addr[0]);
        laneLo = word16 || busWidthSelect || !s_nxt.addr[0];
        // acknowledge hold and float address, data, strobes and chip selects
        s_nxt.pins.holdAcknowledgeN = (s_nxt.fsm != ST_HOLD);
        s_nxt.pins.ctlOe = s_nxt.microMode && (s_nxt.fsm != ST_HOLD);
        if (s_nxt.fsm == ST_ADDR || s_nxt.fsm == ST_STRB) begin
            s_nxt.pins.addrOut = s_nxt.addr;
            s_nxt.pins.addrOe  = 1'b1;
            // chip select of the chosen space
            s_nxt.pins.chipSelectN[s_nxt.csSel] = 1'b0;
            // upper byte enable on odd address or word access
            if (s_nxt.singleStrobe) begin
                s_nxt.pins.highByteStoreStrobeN = !(s_nxt.addr[0] || word16);
            end
        end
        if (s_nxt.fsm == ST_ADDR) begin
            s_nxt.pins.addrLatch = 1'b1;
            if (s_nxt.muxBus) begin
                s_nxt.pins.dataOe = 2'b01;
                // address on the shared low pins
                if (busWidthSelect) begin
                    s_nxt.pins.dataOut[7:0] = s_nxt.addr[7:0];
                end else begin
                    s_nxt.pins.dataOut[7:0] = s_nxt.addr[8:1];
                end
            end
        end
        if (s_nxt.fsm == ST_STRB) begin
            if (!s_nxt.isWrite) begin
                s_nxt.pins.readStrobeN = 1'b0;
            end else begin
                if (s_nxt.singleStrobe) begin
                    s_nxt.pins.lowByteStoreStrobeN = 1'b0;
                end else begin
                    s_nxt.pins.lowByteStoreStrobeN  = !laneLo;
                    s_nxt.pins.highByteStoreStrobeN = !laneHi;
                end
                // high lane only on a 16-bit bus
                s_nxt.pins.dataOe = {laneHi, laneLo};
                if (laneHi && !laneLo) begin
                    s_nxt.pins.dataOut = {s_nxt.wdata[7:0], 8'h00};
                end else if (busWidthSelect) begin
                    s_nxt.pins.dataOut = {8'h00, s_nxt.wdata[7:0]};
                end else begin
                    s_nxt.pins.dataOut = s_nxt.wdata;
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= CORE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_reset_quiet: assert property (
        $past(rst) |-> s_r.fsm == ST_IDLE && !extPins.ctlOe && avs_waitrequest)
        else $error("outputs not idle after reset");
    chk_single_chip: assert property (
        s_r.modeTaken && !s_r.microMode |-> s_r.fsm == ST_IDLE && !extPins.addrOe)
        else $error("bus active in single-chip mode");
    chk_narrow_bus: assert property (
        busWidthSelect |-> !extPins.dataOe[1])
        else $error("high data lane driven on 8-bit bus");
    chk_address_out: assert property (
        s_r.fsm == ST_STRB |-> extPins.addrOe && extPins.addrOut == s_r.addr)
        else $error("address not driven");
    chk_mux_eight: assert property (
        s_r.fsm == ST_ADDR && s_r.muxBus && busWidthSelect
        |-> extPins.dataOut[7:0] == s_r.addr[7:0])
        else $error("8-bit muxed address wrong");
    chk_mux_sixteen: assert property (
        s_r.fsm == ST_ADDR && s_r.muxBus && !busWidthSelect
        |-> extPins.dataOut[7:0] == s_r.addr[8:1])
        else $error("16-bit muxed address wrong");
    chk_chip_select: assert property (
        s_r.fsm == ST_ADDR |-> $onehot(~extPins.chipSelectN)
        && !extPins.chipSelectN[s_r.csSel] ##1 !extPins.chipSelectN[s_r.csSel])
        else $error("chip select wrong");
    chk_even_store: assert property (
        s_r.fsm == ST_STRB && s_r.isWrite && !s_r.singleStrobe && !s_r.addr[0]
        |-> !extPins.lowByteStoreStrobeN)
        else $error("low store strobe missing");
    chk_odd_store: assert property (
        s_r.fsm == ST_STRB && s_r.isWrite && !s_r.singleStrobe && s_r.addr[0]
        |-> !extPins.highByteStoreStrobeN && extPins.lowByteStoreStrobeN)
        else $error("high store strobe wrong");
    chk_read_strobe: assert property (
        s_r.fsm == ST_STRB && !s_r.isWrite
        |-> !extPins.readStrobeN && extPins.lowByteStoreStrobeN)
        else $error("read strobe wrong");
    chk_single_store: assert property (
        s_r.fsm == ST_STRB && s_r.isWrite && s_r.singleStrobe
        |-> !extPins.lowByteStoreStrobeN)
        else $error("write strobe missing");
    chk_upper_enable: assert property (
        s_r.fsm != ST_IDLE && s_r.fsm != ST_HOLD && s_r.singleStrobe && s_r.addr[0]
        |-> !extPins.highByteStoreStrobeN)
        else $error("upper byte enable missing");
    chk_latch_pulse: assert property (
        s_r.fsm == ST_ADDR |-> extPins.addrLatch ##1 !extPins.addrLatch)
        else $error("address latch strobe wrong");
    chk_hold_entry: assert property (
        s_r.fsm == ST_IDLE && s_r.microMode && !holdRequestN
        |=> s_r.fsm == ST_HOLD && !extPins.holdAcknowledgeN)
        else $error("hold not entered");
    chk_hold_float: assert property (
        s_r.fsm == ST_HOLD |-> !extPins.holdAcknowledgeN && !extPins.ctlOe
        && !extPins.addrOe && extPins.dataOe == 2'b00)
        else $error("outputs driven in hold");
    chk_wait_stretch: assert property (
        s_r.fsm == ST_STRB && !waitRequestN |=> s_r.fsm == ST_STRB && !s_r.done)
        else $error("cycle not stretched");

    cov_read_cycle: cover property (
        s_r.fsm == ST_STRB && !s_r.isWrite ##1 s_r.fsm == ST_IDLE);
    cov_waited_write: cover property (
        s_r.fsm == ST_STRB && s_r.isWrite && !waitRequestN ##1 s_r.fsm == ST_STRB);
    cov_hold_cycle: cover property (
        s_r.fsm == ST_HOLD ##1 s_r.fsm == ST_IDLE);
endmodule
`default_nettype wire

/* ext_bus_pkg.sv */
// constants and carrier types for the external memory bus interface
// assumes a single 100 MHz clock and an Avalon-MM register slave
`default_nettype none
package ext_bus_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_ADDR   = 5'h04;
    localparam logic [4:0] OFS_WDATA  = 5'h08;
    localparam logic [4:0] OFS_CMD    = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_RDATA  = 5'h14;
    // field positions
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_MUX    = 1;
    localparam int CMD_GO      = 0;
    localparam int CMD_WRITE   = 1;
    localparam int CMD_WORD    = 2;
    localparam int CMD_CS_LO   = 4;
    localparam int STS_BUSY    = 0;
    localparam int STS_HOLD    = 1;
    localparam int STS_MICRO   = 2;
    localparam int STS_BYTE    = 3;
    localparam int STS_DONE    = 4;
    localparam int STS_WAIT    = 5;
    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 16;
    localparam int CS_N        = 4;

    // one-hot bus sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_STRB = 4'h4,
        ST_HOLD = 4'h8
    } bus_state_e;

    // device pins; address and data have their enables beside them, ctlOe covers strobes and chip selects
    typedef struct packed {
        logic [ADDR_W-1:0] addrOut;
        logic              addrOe;
        logic [DATA_W-1:0] dataOut;
        logic [1:0]        dataOe;     // per byte lane
        logic [CS_N-1:0]   chipSelectN;
        logic              readStrobeN;
        logic              lowByteStoreStrobeN;  // single write strobe in single mode
        logic              highByteStoreStrobeN; // upper byte enable in single mode
        logic              addrLatch;
        logic              ctlOe;      // enables strobes and chip selects
        logic              holdAcknowledgeN;
    } ext_pins_s;

    typedef struct packed {
        bus_state_e        fsm;
        logic              modeTaken;
        logic              microMode;
        logic              singleStrobe;
        logic              muxBus;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        csSel;
        logic              isWrite;
        logic              wordAcc;
        logic              pend;
        logic              done;
        logic              waitReq;
        logic [31:0]       avsRdata;
        ext_pins_s         pins;
    } core_s;

    localparam ext_pins_s PINS_IDLE = '{
        chipSelectN: '1, readStrobeN: 1'b1, lowByteStoreStrobeN: 1'b1,
        highByteStoreStrobeN: 1'b1, holdAcknowledgeN: 1'b1, default: '0};
    localparam core_s CORE_RESET = '{
        fsm: ST_IDLE, waitReq: 1'b1, pins: PINS_IDLE, default: '0};
endpackage
`default_nettype wire

/* ext_mem_model.sv */
// model of the memory and peripherals on the external parallel bus
// assumes registered device pins and a bench that sets the bus options
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
    input  wire logic                   ref_clk,
    input  wire ext_bus_pkg::ext_pins_s pins,
    input  wire logic                   busWidthSelect,
    input  wire logic                   muxMode,
    input  wire logic                   singleMode,
    input  wire logic [1:0]             stretch,
    output logic                        waitRequestN,
    output logic [15:0]                 extDataIn
);
    import ext_bus_pkg::*;
    logic [7:0]  mem [0:2047];
    logic [10:0] base;            // bank, top address bit and low byte
    logic [10:0] even;
    logic [1:0]  bank;
    logic [2:0]  cnt     = 3'h0;
    logic [15:0] lastOut = 16'h0;
    logic        strobing;
    logic        lane0;
    logic        lane1;

    // decode bank, wait and byte lanes from the pins
    always_comb begin
        bank = pins.chipSelectN[0] ? (pins.chipSelectN[1] ?
               (pins.chipSelectN[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
        strobing = !pins.readStrobeN || !pins.lowByteStoreStrobeN
                   || (!singleMode && !pins.highByteStoreStrobeN);
        waitRequestN = !(strobing && cnt < 3'(stretch));
        even = {base[10:1], 1'b0};
        lane0 = !pins.lowByteStoreStrobeN && (singleMode ? !base[0] || busWidthSelect : 1'b1);
        lane1 = !busWidthSelect && (singleMode ?
                !pins.lowByteStoreStrobeN && !pins.highByteStoreStrobeN :
                !pins.highByteStoreStrobeN);
        extDataIn = ~lastOut;     // released bus shows a changing pattern
        if (!pins.readStrobeN && waitRequestN) begin
            if (busWidthSelect)
                extDataIn[7:0] = mem[base];
            else
                extDataIn = {mem[even | 11'h1], mem[even]};
        end
    end

    // capture address, count wait cycles, store written bytes
    always @(posedge ref_clk) begin
        lastOut <= extDataIn;
        cnt <= strobing ? cnt + 3'h1 : 3'h0;
        if (pins.addrLatch === 1'b1)
            base <= {bank, pins.addrOut[19], !muxMode ? pins.addrOut[7:0] :
                     busWidthSelect ? pins.dataOut[7:0] : {pins.dataOut[6:0], pins.addrOut[0]}};
        if (lane0 && waitRequestN)
            mem[busWidthSelect ? base : even] <= pins.dataOut[7:0];
        if (lane1 && waitRequestN)
            mem[even | 11'h1] <= pins.dataOut[15:8];
    end
endmodule
`default_nettype wire

/* external_memory_bus_interface_tb.sv */
// self-checking bench for the external memory bus interface
// assumes the design package, the design and the memory model compiled first
`timescale 1ns/100ps
`default_nettype none
module external_memory_bus_interface_tb;
    import ext_bus_pkg::*;
    typedef struct packed {logic [31:0] val; logic [31:0] msk;} note_s;
    typedef struct packed {logic [19:0] addr; logic [7:0] mb; logic mx;} addr_note_s;
    logic        ref_clk       = 1'b0;
    logic        rst           = 1'b1;
    logic [4:0]  avsAddress    = 5'h00;
    logic        avsRead       = 1'b0;
    logic        avsWrite      = 1'b0;
    logic [31:0] avsWritedata  = 32'h0;
    logic [3:0]  avsByteenable = 4'hF;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        modeSel       = 1'b0;
    logic        widthSel      = 1'b0;
    logic        holdReqN      = 1'b1;
    logic        waitReqN;
    logic        muxMode       = 1'b0;
    logic        singleMode    = 1'b0;
    logic [1:0]  stretch       = 2'h0;
    logic [15:0] extDataIn;
    ext_pins_s   extPins;
    note_s       rdQ[$];
    note_s       rdNote;
    addr_note_s  adQ[$];
    addr_note_s  adNote;
    int          n_mismatch    = 0;
    int          n_tests       = 0;
    int          latchCnt      = 0;

    ext_bus_if uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .processorModeSelect(modeSel),
        .busWidthSelect(widthSel), .holdRequestN(holdReqN), .waitRequestN(waitReqN),
        .extDataIn(extDataIn), .extPins(extPins));
    ext_mem_model mem (.ref_clk(ref_clk), .pins(extPins), .busWidthSelect(widthSel),
        .muxMode(muxMode), .singleMode(singleMode), .stretch(stretch),
        .waitRequestN(waitReqN), .extDataIn(extDataIn));

    // free-running clock
    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one register access, held until waitrequest is seen low
    task automatic avm(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge ref_clk);
        end while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdn(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
        logic [31:0] q;
        rdQ.push_back('{val: v, msk: m});
        avm(1'b0, a, 32'h0, q);
    endtask

    // one external bus cycle, then done is cleared and checked
    task automatic cycle(input logic wr, input logic word, input logic [1:0] cs,
                         input logic [19:0] a, input logic [15:0] d);
        logic [31:0] q;
        int          n;
        stretch <= 2'($urandom_range(3));
        avm(1'b1, OFS_ADDR, 32'(a), q);
        avm(1'b1, OFS_WDATA, 32'(d), q);
        adQ.push_back('{addr: a, mb: widthSel ? a[7:0] : a[8:1], mx: muxMode});
        avm(1'b1, OFS_CMD, {26'h0, cs, 1'b0, word, wr, 1'b1}, q);
        n = 0;
        do begin
            rdQ.push_back('{val: 32'h0, msk: 32'h0});
            avm(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end while (q[STS_DONE] !== 1'b1 && n < 60);
        check(32'(q[STS_DONE]), 32'h1);
        avm(1'b1, OFS_STATUS, 32'h10, q);
        rdn(OFS_STATUS, 32'h0, 32'h11);
    endtask

    task automatic do_reset(input logic mode, input logic w);
        rst <= 1'b1;
        modeSel <= mode;
        widthSel <= w;
        repeat (10) @(posedge ref_clk);
        check({avsWaitrequest, extPins.holdAcknowledgeN, extPins.chipSelectN}, 32'h3F);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // compare each register read answer with the oldest note
    always @(posedge ref_clk) begin
        if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
            if (rdQ.size() == 0)
                check(32'(rdQ.size()), 32'h1); // answer nobody asked for
            else begin
                rdNote = rdQ.pop_front();
                if (rdNote.msk != 32'h0)
                    check(avsReaddata & rdNote.msk, rdNote.val & rdNote.msk);
            end
        end
    end

    // compare each address phase with the oldest started cycle
    always @(posedge ref_clk) begin
        if (extPins.addrLatch === 1'b1) begin
            latchCnt <= latchCnt + 1;
            if (adQ.size() == 0)
                check(32'(extPins.addrOut), 32'hFFFFFFFF);
            else begin
                adNote = adQ.pop_front();
                check(32'(extPins.addrOut), 32'(adNote.addr));
                if (adNote.mx)
                    check(32'(extPins.dataOut[7:0]), 32'(adNote.mb));
            end
        end
    end

    // cut a hung run short
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        logic [2:0]  cfg [5];
        logic [19:0] ad [4];
        logic [15:0] dt [4];
        logic [1:0]  cs [4];
        logic [31:0] q;
        int          c0;
        cfg = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
        void'($urandom(32'hF078));
        // single-chip start: no bus cycle may begin
        do_reset(1'b0, 1'b0);
        rdn(OFS_STATUS, 32'h0, 32'h4);
        avm(1'b1, OFS_CMD, 32'h3, q);
        repeat (10) @(posedge ref_clk);
        rdn(OFS_STATUS, 32'h0, 32'h11);
        rdn(5'h18, 32'h0, 32'hFFFFFFFF);
        avm(1'b1, OFS_WDATA, 32'h1234, q);
        avsByteenable <= 4'h1;
        avm(1'b1, OFS_WDATA, 32'hABCD, q);
        avsByteenable <= 4'hF;
        rdn(OFS_WDATA, 32'h12CD, 32'hFFFF);
        // five of the eight bus width, mux and strobe sets
        foreach (cfg[c]) begin
            do_reset(1'b1, cfg[c][2]);
            muxMode <= cfg[c][1];
            singleMode <= cfg[c][0];
            rdn(OFS_STATUS, {28'h0, cfg[c][2], 3'h4}, 32'hF);
            avm(1'b1, OFS_CTRL, {30'h0, cfg[c][1:0]}, q);
            rdn(OFS_CTRL, {30'h0, cfg[c][1:0]}, 32'h3);
            for (int i = 0; i < 4; i++) begin
                ad[i] = 20'($urandom());
                ad[i][7:5] = 3'(i);
                // one odd byte and one even word every pass
                if (i >= 2)
                    ad[i][0] = (i == 2);
                dt[i] = 16'($urandom());
                cs[i] = 2'($urandom());
                cycle(1'b1, i == 3, cs[i], ad[i], dt[i]);
            end
            for (int i = 0; i < 4; i++) begin
                cycle(1'b0, i == 3, cs[i], ad[i], 16'h0);
                rdn(OFS_RDATA, 32'(dt[i]), (i == 3 && !cfg[c][2]) ? 32'hFFFF : 32'hFF);
            end
        end
        // hold: bus released, a pending cycle waits for the release
        holdReqN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({extPins.holdAcknowledgeN, extPins.addrOe, extPins.dataOe, extPins.ctlOe}, 32'h0);
        rdn(OFS_STATUS, 32'h2, 32'h2);
        c0 = latchCnt;
        fork
            begin
                repeat (30) @(posedge ref_clk);
                check(32'(latchCnt), 32'(c0));
                holdReqN <= 1'b1;
            end
        join_none
        cycle(1'b1, 1'b0, 2'h2, 20'h80A31, 16'h005A);
        cycle(1'b0, 1'b0, 2'h2, 20'h80A31, 16'h0000);
        rdn(OFS_RDATA, 32'h5A, 32'hFF);
        check(32'(extPins.holdAcknowledgeN), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
